// [hw/tfc_consts.vh]
// Purpose: constants for the tunable filter control register bank
// Assumes: 15-bit register addresses, 8-bit registers, serial frame MSB first
// Notes: definitions only
`ifndef TFC_CONSTS_VH
`define TFC_CONSTS_VH

// register offsets
`define TFC_ADDR_PART_HIGH 15'h0005
`define TFC_ADDR_REVISION 15'h000c
`define TFC_ADDR_SEQ_STOP 15'h0011
`define TFC_ADDR_SEQ_START 15'h0012
`define TFC_ADDR_SEQ_DIR 15'h0013
`define TFC_ADDR_SEQ_POS 15'h0014
`define TFC_ADDR_DIR_CENTER 15'h0020
`define TFC_ADDR_DIR_WIDTH 15'h0021
`define TFC_ADDR_DIR_MATCH 15'h0022
`define TFC_ADDR_SETUP 15'h0050
`define TFC_ADDR_RB_CENTER 15'h0060
`define TFC_ADDR_RB_WIDTH 15'h0061
`define TFC_ADDR_RB_MATCH 15'h0062
`define TFC_ADDR_LUT_FIRST 15'h0100
`define TFC_ADDR_LUT_LAST 15'h015f

// field positions
`define TFC_INDEX_MSB 6
`define TFC_DIR_BIT 0
`define TFC_AUTO_BIT 0
`define TFC_REV_MSB 3

// reset values
`define TFC_RST_STOP 7'h7f
`define TFC_RST_START 7'h00
`define TFC_RST_CODE 8'h00

// serial frame layout: read flag, 15 address bits, 8 data bits
`define TFC_FRAME_ADDR_BITS 5'h10
`define TFC_FRAME_BITS 5'h18
`define TFC_SDO_LOAD_DELAY 2'h2

`endif

// [hw/tfc_lut_mem.v]
// Purpose: lookup table store, one word of three 8-bit codes per entry
// Assumes: single clock, registered read, byte lane write enables
// Notes: lane 0 centre, lane 1 width, lane 2 match
module tfc_lut_mem #(
	parameter ENTRIES = 32,
	parameter AW = 5
) (
	// clocking
	input wire clk,
	input wire resetn,
	input wire ce,
	// write side
	input wire [AW-1:0] waddr,
	input wire [2:0] wlane,
	input wire [7:0] wdata,
	// read side
	input wire [AW-1:0] raddr,
	output reg [23:0] rdata
);
	reg [23:0] mem [0:ENTRIES-1];
	integer i;

	// table entries reset to zero, lanes written one byte at a time
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (i = 0; i < ENTRIES; i = i + 1) begin
				mem[i] <= 24'h00_0000;
			end
			rdata <= 24'h00_0000;
		end else if (ce) begin
			if (wlane[0]) mem[waddr][7:0] <= wdata;
			if (wlane[1]) mem[waddr][15:8] <= wdata;
			if (wlane[2]) mem[waddr][23:16] <= wdata;
			rdata <= mem[raddr];
		end
	end
endmodule

// [hw/tfc_regs.v]
// Purpose: register bank and table sequencer of a tunable band-pass filter
// Assumes: serial port pins synchronous to clk, sclk phases at least 4 clk long
// Notes: frame is read flag, 15-bit address, 8 data bits; sdo loads 2 clk after the 16th sclk rise, then changes on sclk fall
`include "tfc_consts.vh"
module tfc_regs #(
	parameter [7:0] PART_CODE_HIGH = 8'h5a, // arbitrary value
	parameter [3:0] REVISION_CODE = 4'h3, // arbitrary value
	parameter LUT_ENTRIES = 32
) (
	// clocking
	input wire clk,
	input wire resetn,
	input wire ce,
	// serial port
	input wire sclk,
	input wire cs_n,
	input wire sdi,
	output reg sdo,
	// sequencing and interpolation inputs
	input wire table_sequencing_mode,
	input wire [7:0] auto_center_code,
	input wire [7:0] auto_width_code,
	input wire [7:0] auto_match_code,
	// codes applied to the filter
	output reg [7:0] applied_center_code,
	output reg [7:0] applied_width_code,
	output reg [7:0] applied_match_code
);
	// maps a table offset to entry and lane, used for reads and writes
	function [6:0] lut_entry;
		input [6:0] off;
		begin
			lut_entry = off / 7'h03;
		end
	endfunction
	function [2:0] lut_lane;
		input [6:0] off;
		reg [6:0] rem;
		begin
			rem = off - lut_entry(off) * 7'h03;
			lut_lane = (rem == 7'h00) ? 3'b001 : (rem == 7'h01) ? 3'b010 : 3'b100;
		end
	endfunction

	// register state
	reg [6:0] stop_r, start_r, pos_r;
	reg dir_r, auto_r;
	reg [7:0] dcenter_r, dwidth_r, dmatch_r;
	// serial port state
	reg sclk_q, cs_n_q;
	reg [4:0] bit_cnt_r;
	reg [22:0] shin_r;
	reg rd_r;
	reg [14:0] addr_r;
	reg [7:0] shout_r;
	reg [1:0] load_cnt_r;
	reg fetch_r;
	wire [23:0] lut_rdata;

	wire sclk_rise = sclk & ~sclk_q & ~cs_n;
	wire sclk_fall = ~sclk & sclk_q & ~cs_n;
	wire cs_rise = cs_n & ~cs_n_q;
	wire [4:0] bit_cnt_inc = bit_cnt_r + 5'h01;
	wire addr_done = sclk_rise & (bit_cnt_inc == `TFC_FRAME_ADDR_BITS);
	wire data_done = sclk_rise & (bit_cnt_inc == `TFC_FRAME_BITS) & ~rd_r;
	wire [14:0] frame_addr = {shin_r[13:0], sdi};
	wire [7:0] wr_data = {shin_r[6:0], sdi};
	wire wr_stop = data_done & (addr_r == `TFC_ADDR_SEQ_STOP);
	wire wr_start = data_done & (addr_r == `TFC_ADDR_SEQ_START);
	wire wr_dir = data_done & (addr_r == `TFC_ADDR_SEQ_DIR);
	wire in_lut = (addr_r >= `TFC_ADDR_LUT_FIRST) && (addr_r <= `TFC_ADDR_LUT_LAST);
	wire [14:0] lut_off_full = addr_r - `TFC_ADDR_LUT_FIRST;
	wire [6:0] lut_off = lut_off_full[6:0]; // table offsets reach 0x5f, fits 7 bits
	wire [6:0] lut_ent = lut_entry(lut_off);
	wire [2:0] lut_wlane = (data_done & in_lut) ? lut_lane(lut_off) : 3'b000;

	// sequencer next values after a write and after a step
	reg [6:0] stop_nxt, start_nxt, pos_nxt, step_pos;
	reg dir_nxt;
	always @* begin
		stop_nxt = wr_stop ? wr_data[`TFC_INDEX_MSB:0] : stop_r;
		start_nxt = wr_start ? wr_data[`TFC_INDEX_MSB:0] : start_r;
		dir_nxt = wr_dir ? wr_data[`TFC_DIR_BIT] : dir_r;
		if (!dir_r) begin
			step_pos = (pos_r == stop_r) ? start_r : pos_r + 7'h01;
		end else begin
			step_pos = (pos_r == start_r) ? stop_r : pos_r - 7'h01;
		end
		pos_nxt = pos_r;
		if (fetch_r) begin
			pos_nxt = step_pos;
		end
		if ((stop_nxt != stop_r) || (start_nxt != start_r) || (dir_nxt != dir_r)) begin
			pos_nxt = dir_nxt ? stop_nxt : start_nxt;
		end
	end

	// control registers and sequencer position
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stop_r <= `TFC_RST_STOP;
			start_r <= `TFC_RST_START;
			dir_r <= 1'b0;
			pos_r <= 7'h00;
			auto_r <= 1'b0;
			dcenter_r <= `TFC_RST_CODE;
			dwidth_r <= `TFC_RST_CODE;
			dmatch_r <= `TFC_RST_CODE;
		end else if (ce) begin
			stop_r <= stop_nxt;
			start_r <= start_nxt;
			dir_r <= dir_nxt;
			pos_r <= pos_nxt;
			if (data_done && addr_r == `TFC_ADDR_SETUP) auto_r <= wr_data[`TFC_AUTO_BIT];
			if (data_done && addr_r == `TFC_ADDR_DIR_CENTER) dcenter_r <= wr_data;
			if (data_done && addr_r == `TFC_ADDR_DIR_WIDTH) dwidth_r <= wr_data;
			if (data_done && addr_r == `TFC_ADDR_DIR_MATCH) dmatch_r <= wr_data;
		end
	end

	// applied codes: table entry on each cs rise in sequencing mode, else source per auto bit
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fetch_r <= 1'b0;
			applied_center_code <= `TFC_RST_CODE;
			applied_width_code <= `TFC_RST_CODE;
			applied_match_code <= `TFC_RST_CODE;
		end else if (ce) begin
			fetch_r <= cs_rise & table_sequencing_mode;
			if (table_sequencing_mode) begin
				if (fetch_r) begin
					applied_center_code <= lut_rdata[7:0];
					applied_width_code <= lut_rdata[15:8];
					applied_match_code <= lut_rdata[23:16];
				end
			end else if (auto_r) begin
				applied_center_code <= auto_center_code;
				applied_width_code <= auto_width_code;
				applied_match_code <= auto_match_code;
			end else begin
				applied_center_code <= dcenter_r;
				applied_width_code <= dwidth_r;
				applied_match_code <= dmatch_r;
			end
		end
	end

	// read data for the latched address
	reg [7:0] rd_data;
	always @* begin
		rd_data = 8'h00;
		case (addr_r)
			`TFC_ADDR_PART_HIGH: rd_data = PART_CODE_HIGH;
			`TFC_ADDR_REVISION: rd_data = {4'h0, REVISION_CODE};
			`TFC_ADDR_SEQ_STOP: rd_data = {1'b0, stop_r};
			`TFC_ADDR_SEQ_START: rd_data = {1'b0, start_r};
			`TFC_ADDR_SEQ_DIR: rd_data = {7'h00, dir_r};
			`TFC_ADDR_SEQ_POS: rd_data = {1'b0, pos_r};
			`TFC_ADDR_DIR_CENTER: rd_data = dcenter_r;
			`TFC_ADDR_DIR_WIDTH: rd_data = dwidth_r;
			`TFC_ADDR_DIR_MATCH: rd_data = dmatch_r;
			`TFC_ADDR_SETUP: rd_data = {7'h00, auto_r};
			`TFC_ADDR_RB_CENTER: rd_data = applied_center_code;
			`TFC_ADDR_RB_WIDTH: rd_data = applied_width_code;
			`TFC_ADDR_RB_MATCH: rd_data = applied_match_code;
			default: begin
				if (in_lut) begin
					case (lut_lane(lut_off))
						3'b001: rd_data = lut_rdata[7:0];
						3'b010: rd_data = lut_rdata[15:8];
						default: rd_data = lut_rdata[23:16];
					endcase
				end
			end
		endcase
	end

	// serial frame: shift in on sclk rise, shift out on sclk fall
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
			bit_cnt_r <= 5'h00;
			shin_r <= 23'h00_0000;
			rd_r <= 1'b0;
			addr_r <= 15'h0000;
			shout_r <= 8'h00;
			load_cnt_r <= 2'h0;
			sdo <= 1'b0;
		end else if (ce) begin
			sclk_q <= sclk;
			cs_n_q <= cs_n;
			if (cs_n) begin
				bit_cnt_r <= 5'h00;
				load_cnt_r <= 2'h0;
			end else if (sclk_rise) begin
				shin_r <= {shin_r[21:0], sdi};
				if (bit_cnt_r != `TFC_FRAME_BITS) bit_cnt_r <= bit_cnt_inc;
				if (bit_cnt_r == 5'h00) rd_r <= sdi;
			end
			if (addr_done) begin
				addr_r <= frame_addr;
				load_cnt_r <= rd_r ? `TFC_SDO_LOAD_DELAY : 2'h0;
			end else if (load_cnt_r != 2'h0) begin
				load_cnt_r <= load_cnt_r - 2'h1;
				if (load_cnt_r == 2'h1) begin
					shout_r <= rd_data;
					sdo <= rd_data[7];
				end
			end else if (sclk_fall && bit_cnt_r > `TFC_FRAME_ADDR_BITS && rd_r) begin
				shout_r <= {shout_r[6:0], 1'b0};
				sdo <= shout_r[6];
			end
		end
	end

	// table store; the serial port owns the read address during a frame
	tfc_lut_mem #(
		.ENTRIES(LUT_ENTRIES),
		.AW(5)
	) u_lut (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.waddr(lut_ent[4:0]),
		.wlane(lut_wlane),
		.wdata(wr_data),
		.raddr(cs_n ? pos_r[4:0] : lut_ent[4:0]),
		.rdata(lut_rdata)
	);
endmodule

// [sim/tfc_host_model.sv]
// Purpose: serial host that sends 24-bit register frames
// Assumes: mode 0, sclk phases of 5 clk
// Notes: idle sdi shows the inverse of its last bit
module tfc_host_model (
	// clock
	input wire clk,
	// serial port
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	input wire sdo
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle levels
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end
	// one frame, read data taken just before each of the last 8 rises
	task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d, output logic [7:0] q);
		logic [23:0] f;
		f = {rd, a, d};
		q = 8'h00;
		@(negedge clk) cs_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdi = f[i];
			repeat (5) @(negedge clk);
			if (i < 8) q = {q[6:0], sdo};
			sclk = 1'b1;
			repeat (5) @(negedge clk);
			sclk = 1'b0;
		end
		repeat (5) @(negedge clk);
		cs_n = 1'b1;
		sdi = ~sdi; // released line
		repeat (6) @(negedge clk);
	endtask
endmodule

// [sim/tfc_regs_checker.sv]
// Purpose: port checks of the filter register bank
// Assumes: sclk phases of at least 5 clk
// Notes: bound into tfc_regs
module tfc_regs_checker (
	// clocking
	input wire clk,
	input wire resetn,
	input wire ce,
	// serial port
	input wire sclk,
	input wire cs_n,
	input wire sdi,
	input wire sdo,
	// codes
	input wire table_sequencing_mode,
	input wire [7:0] auto_center_code,
	input wire [7:0] auto_width_code,
	input wire [7:0] auto_match_code,
	input wire [7:0] applied_center_code,
	input wire [7:0] applied_width_code,
	input wire [7:0] applied_match_code
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// table mode held and no select rise lately
	sequence s_quiet;
		table_sequencing_mode && $past(table_sequencing_mode) && $past(table_sequencing_mode, 2)
			&& !cs_n && !$past(cs_n) && !$past(cs_n, 2);
	endsequence
	// select rise in table mode
	sequence s_fetch;
		$rose(cs_n) && table_sequencing_mode;
	endsequence
	a_reset_center_zero: assert property ($rose(resetn) |-> applied_center_code == 8'h00) else $error("centre not cleared");
	a_reset_other_zero: assert property ($rose(resetn) |-> applied_width_code == 8'h00 && applied_match_code == 8'h00)
		else $error("codes not cleared");
	a_reset_sdo_low: assert property ($rose(resetn) |-> !sdo) else $error("sdo not cleared");
	a_quiet_center_hold: assert property (s_quiet |-> $stable(applied_center_code)) else $error("centre moved");
	a_quiet_width_hold: assert property (s_quiet |-> $stable(applied_width_code)) else $error("width moved");
	a_quiet_match_hold: assert property (s_quiet |-> $stable(applied_match_code)) else $error("match moved");
	a_fetch_two_cycles: assert property (s_fetch |=> $stable(applied_center_code)) else $error("fetch early");
	a_sdo_high_hold: assert property (!cs_n && sclk && $past(sclk, 4) |-> $stable(sdo)) else $error("sdo moved");
endmodule
bind tfc_regs tfc_regs_checker i_chk (.clk(clk), .resetn(resetn), .ce(ce), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
	.sdo(sdo), .table_sequencing_mode(table_sequencing_mode), .auto_center_code(auto_center_code),
	.auto_width_code(auto_width_code), .auto_match_code(auto_match_code), .applied_center_code(applied_center_code),
	.applied_width_code(applied_width_code), .applied_match_code(applied_match_code));

// [sim/tb_top.sv]
// Purpose: self-checking bench of the filter register bank
// Assumes: inputs change on the falling clk edge
// Notes: table rows first, then reset, code source and sequencer
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [14:0] a; logic [7:0] wd; logic [7:0] ex; logic [7:0] rs;} tfc_row_t;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic mode = 1'b0;
	logic ce = 1'b1;
	logic [7:0] ac = 8'h4e;
	logic [7:0] aw = 8'h9d;
	logic [7:0] am = 8'h17;
	logic sclk, cs_n, sdi, sdo;
	logic [7:0] app_c, app_w, app_m, q;
	int error_cnt = 0;
	int n_compared = 0;
	// address, write value, readback, reset value
	tfc_row_t rows [15] = '{'{15'h0005, 8'hff, 8'h5a, 8'h5a}, '{15'h000c, 8'hff, 8'h03, 8'h03},
		'{15'h0011, 8'h95, 8'h15, 8'h7f}, '{15'h0012, 8'h83, 8'h03, 8'h00}, '{15'h0013, 8'hfe, 8'h00, 8'h00},
		'{15'h0014, 8'h55, 8'h03, 8'h00}, '{15'h0020, 8'ha5, 8'ha5, 8'h00}, '{15'h0021, 8'h3c, 8'h3c, 8'h00},
		'{15'h0022, 8'h5e, 8'h5e, 8'h00},
		'{15'h0050, 8'hfe, 8'h00, 8'h00}, '{15'h0060, 8'h11, 8'ha5, 8'h00}, '{15'h0061, 8'h11, 8'h3c, 8'h00},
		'{15'h0062, 8'h11, 8'h5e, 8'h00},
		'{15'h015f, 8'h69, 8'h69, 8'h00}, '{15'h0030, 8'h77, 8'h00, 8'h00}};
	always #25 clk = ~clk;
	// design and host
	tfc_regs i_tfc_regs (.clk(clk), .resetn(resetn), .ce(ce), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
		.table_sequencing_mode(mode), .auto_center_code(ac), .auto_width_code(aw), .auto_match_code(am),
		.applied_center_code(app_c), .applied_width_code(app_w), .applied_match_code(app_m));
	tfc_host_model i_tfc_host_model (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
	task automatic chk8(input string nm, input logic [7:0] ex, input logic [7:0] got);
		n_compared++;
		if (got !== ex) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		logic [7:0] dummy;
		i_tfc_host_model.xfer(1'b0, a, d, dummy);
	endtask
	task automatic do_reset();
		resetn = 1'b0;
		repeat (16) @(negedge clk);
		resetn = 1'b1;
		repeat (2) @(negedge clk);
	endtask
	task automatic summarize();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// main sequence
	initial begin
		do_reset();
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].wd);
			i_tfc_host_model.xfer(1'b1, rows[i].a, 8'h00, q);
			chk8("readback", rows[i].ex, q);
		end
		do_reset();
		chk8("applied", 8'h00, app_c | app_w | app_m);
		foreach (rows[i]) begin
			i_tfc_host_model.xfer(1'b1, rows[i].a, 8'h00, q);
			chk8("reset value", rows[i].rs, q);
		end
		wr(15'h0020, 8'h2d);
		wr(15'h0050, 8'h01);
		ac = 8'hb1;
		repeat (3) @(negedge clk);
		chk8("auto centre", 8'hb1, app_c);
		chk8("auto width", 8'h9d, app_w);
		chk8("auto match", 8'h17, app_m);
		wr(15'h0050, 8'h00);
		chk8("direct centre", 8'h2d, app_c);
		wr(15'h0012, 8'h02);
		wr(15'h0011, 8'h03);
		for (int k = 0; k < 6; k++) wr(15'(15'h0106 + k), 8'(8'h40 + k));
		mode = 1'b1;
		for (int k = 0; k < 3; k++) begin
			i_tfc_host_model.xfer(1'b1, 15'h0014, 8'h00, q);
			chk8("position", 8'(2 + k % 2), q);
			chk8("table centre", 8'(8'h40 + 3 * (k % 2)), app_c);
			chk8("table match", 8'(8'h42 + 3 * (k % 2)), app_m);
		end
		wr(15'h0013, 8'h01);
		chk8("reinit centre", 8'h43, app_c);
		i_tfc_host_model.xfer(1'b1, 15'h0014, 8'h00, q);
		chk8("down position", 8'h02, q);
		i_tfc_host_model.xfer(1'b1, 15'h0014, 8'h00, q);
		chk8("down wrap", 8'h03, q);
		// a frame sent while the clock enable is low must leave no trace
		ce = 1'b0;
		wr(15'h0020, 8'h77);
		ce = 1'b1;
		i_tfc_host_model.xfer(1'b1, 15'h0020, 8'h00, q);
		chk8("frozen write", 8'h2d, q);
		summarize();
	end
	// hang guard
	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		summarize();
	end
endmodule
